// *** include/csss_map.svh ***
// Purpose: offsets, field positions, reset values and counts of the clock sequencer
// Assumes: 8-bit register port, 4-bit address
// Notes: definitions only
`ifndef CSSS_MAP_SVH
`define CSSS_MAP_SVH

// Register offsets
`define CSSS_ADDR_CTRL 4'h0
`define CSSS_ADDR_STATUS 4'h4
`define CSSS_ADDR_FUSE 4'h8

// Control fields
`define CSSS_CTRL_MODE_LSB 0
`define CSSS_CTRL_MODE_MSB 2
`define CSSS_CTRL_SLEEP_GO 3
`define CSSS_CTRL_NVM_OFF 4
`define CSSS_CTRL_RST 8'h00

// Clock select codes (programmed bit reads zero)
`define CSSS_CK_RC128 4'h3
`define CSSS_CK_RCCAL 4'h2
`define CSSS_CK_EXT 4'h0
`define CSSS_CK_RSVD 4'h1
`define CSSS_CK_FS 3'h3
`define CSSS_CK_LF 3'h2
`define CSSS_FUSE_PROG 1'h0

// Time-out, start-up and prescaler counts, in oscillator cycles
`define CSSS_TOUT_4K 16'h1000
`define CSSS_START_1K 16'h0400
`define CSSS_START_SHORT 16'h0006
`define CSSS_DIV_LAST 3'h7

// Oscillator input lanes
`define CSSS_LANE_WDT 6
`define CSSS_LANE_ASY 7
`endif

// *** include/csss_pkg.sv ***
// Purpose: types of the clock select and start-up sequencer
// Assumes: nothing
// Notes: numbers live in csss_map.svh
package csss_pkg;
	typedef enum logic [2:0] {
		ST_HOLD = 3'h0,
		ST_TOUT = 3'h1,
		ST_START = 3'h2,
		ST_RUN = 3'h3,
		ST_SLEEP = 3'h4,
		ST_WAKE = 3'h5,
		ST_BAD = 3'h6
	} csss_state_t;

	// Source index equals the oscillator input lane
	typedef enum logic [2:0] {
		SRC_LP = 3'h0,
		SRC_FS = 3'h1,
		SRC_LF = 3'h2,
		SRC_RC128 = 3'h3,
		SRC_RCCAL = 3'h4,
		SRC_EXT = 3'h5,
		SRC_NONE = 3'h7
	} csss_src_t;

	typedef enum logic [2:0] {
		SLP_IDLE = 3'h0,
		SLP_ADC = 3'h1,
		SLP_PDOWN = 3'h2,
		SLP_PSAVE = 3'h3,
		SLP_STBY = 3'h4
	} csss_sleep_t;
endpackage

// *** src/csss_presc.sv ***
// Purpose: system prescaler between clock multiplexer and domain gates
// Assumes: tick_i is a one-cycle pulse per source edge
// Notes: divides by eight when div8_i is high
`timescale 1ns/10ps
`include "csss_map.svh"
module csss_presc (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic div8_i,
	output logic tick_o
);
	logic [2:0] cnt_r;
	wire last = (cnt_r == `CSSS_DIV_LAST);

	// Count source edges; pass every one or every eighth
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 3'h0;
			tick_o <= 1'b0;
		end else begin
			if (tick_i)
				cnt_r <= cnt_r + 3'h1;
			tick_o <= tick_i & (~div8_i | last);
		end
	end

	chk_div_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
		tick_o && div8_i |=> !tick_o [*7])
		else $error("prescaler ticks closer than eight source edges");
endmodule

// *** src/csss_top.sv ***
// Purpose: clock source select, prescaler, domain gating and start-up sequencing
// Assumes: oscillators and reset sources arrive as slow pins sampled on clk_i
// Notes: gated domains are given as one-cycle clock ticks on clk_i
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "csss_map.svh"
module csss_top #(
	parameter logic [15:0] TOUT_8K_CYC = 16'h2000,
	parameter logic [15:0] START_16K_CYC = 16'h4000,
	parameter logic [15:0] START_32K_CYC = 16'h8000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rst_src_i,
	input wire logic [7:0] osc_i,
	input wire logic [3:0] clock_source_select_i,
	input wire logic [1:0] startup_time_select_i,
	input wire logic divide_by_eight_fuse_i,
	input wire logic async_int_i,
	input wire logic addr_match_i,
	input wire logic periph_int_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	output logic int_rst_o,
	output logic core_clock_o,
	output logic peripheral_clock_o,
	output logic nvm_clock_o,
	output logic async_timer_clock_o,
	output logic converter_clock_o
);
	csss_pkg::csss_state_t state_r;
	csss_pkg::csss_state_t state_nxt;
	csss_pkg::csss_src_t src_r;
	csss_pkg::csss_src_t src_dec;
	csss_pkg::csss_sleep_t mode_r;
	logic [7:0] osc_s1_r;
	logic [7:0] osc_s2_r;
	logic [7:0] osc_s3_r;
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	logic [3:0] csel_r;
	logic [1:0] stsel_r;
	logic div8_r;
	logic nvm_off_r;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic [7:0] rdata_nxt;
	logic presc_tick;

	// Two flops per oscillator lane, third only for edge finding
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_osc
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					osc_s1_r[g] <= 1'b0;
					osc_s2_r[g] <= 1'b0;
					osc_s3_r[g] <= 1'b0;
				end else begin
					osc_s1_r[g] <= osc_i[g];
					osc_s2_r[g] <= osc_s1_r[g];
					osc_s3_r[g] <= osc_s2_r[g];
				end
			end
		end
	endgenerate

	// Reset source and wake pins are asynchronous too
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_r <= 3'h0;
			pin_s2_r <= 3'h0;
		end else begin
			pin_s1_r <= {rst_src_i, async_int_i, addr_match_i};
			pin_s2_r <= pin_s1_r;
		end
	end

	wire [7:0] osc_edge = osc_s2_r & ~osc_s3_r;
	wire ext_rst = pin_s2_r[2];
	wire wdt_tick = osc_edge[`CSSS_LANE_WDT];
	wire asy_tick = osc_edge[`CSSS_LANE_ASY];
	// A stopped peripheral clock cannot see periph_int_i; async pins always wake
	wire wake_async = pin_s2_r[1] | pin_s2_r[0];

	// Fuse decode; zero means programmed
	wire [3:0] ck = clock_source_select_i;
	assign src_dec = ck[3] ? csss_pkg::SRC_LP :
		(ck[3:1] == `CSSS_CK_FS) ? csss_pkg::SRC_FS :
		(ck[3:1] == `CSSS_CK_LF) ? csss_pkg::SRC_LF :
		(ck == `CSSS_CK_RC128) ? csss_pkg::SRC_RC128 :
		(ck == `CSSS_CK_RCCAL) ? csss_pkg::SRC_RCCAL :
		(ck == `CSSS_CK_EXT) ? csss_pkg::SRC_EXT :
		csss_pkg::SRC_NONE;
	wire div8_dec = (divide_by_eight_fuse_i == `CSSS_FUSE_PROG);

	// Fuses are caught only while held in reset, never while running
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			src_r <= csss_pkg::SRC_NONE;
			csel_r <= `CSSS_CK_RSVD;
			stsel_r <= 2'h0;
			div8_r <= 1'b0;
		end else if (state_r == csss_pkg::ST_HOLD) begin
			src_r <= src_dec;
			csel_r <= clock_source_select_i;
			stsel_r <= startup_time_select_i;
			div8_r <= div8_dec;
		end
	end

	// Time-out length from the start-up fuses; 10 and 11 pick the longest
	wire [15:0] tout_lim = (stsel_r == 2'h0) ? 16'h0000 :
		(stsel_r == 2'h1) ? `CSSS_TOUT_4K : TOUT_8K_CYC;
	wire tout_off = (tout_lim == 16'h0000);
	// Crystals need long settling; RC and external clocks only a few edges
	wire xtal = (src_r == csss_pkg::SRC_LP) | (src_r == csss_pkg::SRC_FS);
	wire [15:0] start_lim = xtal ? (csel_r[0] ? START_16K_CYC : `CSSS_START_1K) :
		(src_r == csss_pkg::SRC_LF) ? START_32K_CYC : `CSSS_START_SHORT;

	// Multiplexer: selected lane edge, none for the reserved code
	wire src_ok = (src_r != csss_pkg::SRC_NONE);
	wire src_tick = src_ok & osc_edge[src_r];

	// Prescaler sits after the multiplexer, before every gate but the async timer's, which takes asy_tick directly
	csss_presc u_presc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(src_tick),
		.div8_i(div8_r),
		.tick_o(presc_tick)
	);

	// Register port decode
	wire hit_ctrl = (addr_i == `CSSS_ADDR_CTRL);
	wire hit_stat = (addr_i == `CSSS_ADDR_STATUS);
	wire hit_fuse = (addr_i == `CSSS_ADDR_FUSE);
	wire ctrl_wr = wr_i & hit_ctrl;
	wire sleep_go = ctrl_wr & wdata_i[`CSSS_CTRL_SLEEP_GO];
	wire [2:0] wmode = wdata_i[`CSSS_CTRL_MODE_MSB:`CSSS_CTRL_MODE_LSB];
	wire [7:0] ctrl_rd = {3'h0, nvm_off_r, 1'b0, mode_r};
	wire [7:0] stat_rd = {~src_ok, div8_r, src_r, state_r};
	wire [7:0] fuse_rd = {1'b0, ~div8_r, stsel_r, csel_r};

	// Unmapped addresses read zero; data stands one cycle only
	always_comb begin
		rdata_nxt = 8'h00;
		if (rd_i) begin
			if (hit_ctrl)
				rdata_nxt = ctrl_rd;
			else if (hit_stat)
				rdata_nxt = stat_rd;
			else if (hit_fuse)
				rdata_nxt = fuse_rd;
		end
	end

	// Control register; the go bit is acted on, never stored
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_r <= csss_pkg::SLP_IDLE;
			nvm_off_r <= 1'b0;
		end else if (ctrl_wr) begin
			mode_r <= csss_pkg::csss_sleep_t'(wmode);
			nvm_off_r <= wdata_i[`CSSS_CTRL_NVM_OFF];
		end
	end

	wire deep = (mode_r == csss_pkg::SLP_PDOWN) | (mode_r == csss_pkg::SLP_PSAVE);
	wire io_on_sleep = (mode_r == csss_pkg::SLP_IDLE);
	wire adc_on_sleep = io_on_sleep | (mode_r == csss_pkg::SLP_ADC);
	// A peripheral interrupt is only seen while its clock runs
	wire wake = wake_async | (io_on_sleep & periph_int_i);

	// Sequencer: hold, time-out, start-up, run, sleep and wake
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			csss_pkg::ST_HOLD: begin
				cnt_nxt = 16'h0000;
				if (!ext_rst) begin
					if (src_r == csss_pkg::SRC_NONE)
						state_nxt = csss_pkg::ST_BAD;
					else if (tout_off)
						state_nxt = csss_pkg::ST_START;
					else
						state_nxt = csss_pkg::ST_TOUT;
				end
			end
			csss_pkg::ST_TOUT: begin
				if (wdt_tick) begin
					cnt_nxt = cnt_r + 16'h0001;
					if (cnt_r == tout_lim - 16'h0001) begin
						cnt_nxt = 16'h0000;
						state_nxt = csss_pkg::ST_START;
					end
				end
			end
			csss_pkg::ST_START, csss_pkg::ST_WAKE: begin
				if (src_tick) begin
					cnt_nxt = cnt_r + 16'h0001;
					if (cnt_r == start_lim - 16'h0001) begin
						cnt_nxt = 16'h0000;
						state_nxt = csss_pkg::ST_RUN;
					end
				end
			end
			csss_pkg::ST_RUN: begin
				if (sleep_go)
					state_nxt = csss_pkg::ST_SLEEP;
			end
			csss_pkg::ST_SLEEP: begin
				cnt_nxt = 16'h0000;
				if (wake)
					state_nxt = deep ? csss_pkg::ST_WAKE : csss_pkg::ST_RUN;
			end
			csss_pkg::ST_BAD: begin
				state_nxt = csss_pkg::ST_BAD;
			end
			default: begin
				state_nxt = csss_pkg::ST_HOLD;
				cnt_nxt = 16'h0000;
			end
		endcase
		// Any other reset source restarts the whole sequence
		if (ext_rst) begin
			state_nxt = csss_pkg::ST_HOLD;
			cnt_nxt = 16'h0000;
		end
	end

	// Sleep and wake while deep sleep never pass the time-out again
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= csss_pkg::ST_HOLD;
			cnt_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Domain enables, one per domain
	wire run = (state_r == csss_pkg::ST_RUN);
	wire slp = (state_r == csss_pkg::ST_SLEEP);
	wire core_en = run;
	wire nvm_en = run & ~nvm_off_r;
	wire io_en = run | (slp & io_on_sleep);
	wire adc_en = run | (slp & adc_on_sleep);
	// Timer crystal is its own lane, alive in any sleep mode
	wire asy_en = run | slp | (state_r == csss_pkg::ST_WAKE);

	// Outputs all flop; internal reset is held until the run state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
			int_rst_o <= 1'b1;
			core_clock_o <= 1'b0;
			peripheral_clock_o <= 1'b0;
			nvm_clock_o <= 1'b0;
			async_timer_clock_o <= 1'b0;
			converter_clock_o <= 1'b0;
		end else begin
			rdata_o <= rdata_nxt;
			int_rst_o <= ~(run | slp);
			core_clock_o <= presc_tick & core_en;
			peripheral_clock_o <= presc_tick & io_en;
			nvm_clock_o <= presc_tick & nvm_en;
			async_timer_clock_o <= asy_tick & asy_en;
			converter_clock_o <= presc_tick & adc_en;
		end
	end

	chk_decode_sel: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == csss_pkg::ST_HOLD && ck == `CSSS_CK_RCCAL
		|=> src_r == csss_pkg::SRC_RCCAL)
		else $error("calibrated RC code not decoded");

	chk_fuse_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == csss_pkg::ST_HOLD |=> div8_r == !$past(divide_by_eight_fuse_i))
		else $error("divide fuse polarity wrong");

	chk_default_fuse: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == csss_pkg::ST_HOLD && ck == `CSSS_CK_RCCAL
		&& startup_time_select_i == 2'h2 && !divide_by_eight_fuse_i
		|=> div8_r && tout_lim == TOUT_8K_CYC && start_lim == `CSSS_START_SHORT)
		else $error("shipped fuse setting not honoured");

	chk_tout_held: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == csss_pkg::ST_TOUT |=> int_rst_o)
		else $error("internal reset dropped during time-out");

	chk_tout_length: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == csss_pkg::ST_TOUT && state_nxt == csss_pkg::ST_START
		|-> wdt_tick && cnt_r == tout_lim - 16'h0001)
		else $error("time-out ended at wrong count");

	chk_start_length: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == csss_pkg::ST_START && state_nxt == csss_pkg::ST_RUN
		|-> src_tick && cnt_r == start_lim - 16'h0001)
		else $error("start-up ended at wrong count");

	chk_release_run: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(int_rst_o) |-> $past(state_r) == csss_pkg::ST_RUN)
		else $error("reset released before start-up finished");

	chk_wake_path: assert property (@(posedge clk_i) disable iff (rst_i)
		slp && wake && !ext_rst |=> state_r == (deep ? csss_pkg::ST_WAKE : csss_pkg::ST_RUN))
		else $error("wake did not skip the time-out");

	chk_core_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		core_clock_o |-> $past(state_r) == csss_pkg::ST_RUN)
		else $error("core clock outside run");

	chk_nvm_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(nvm_off_r) |-> nvm_clock_o == core_clock_o)
		else $error("memory clock not with core clock");

	chk_async_wake: assert property (@(posedge clk_i) disable iff (rst_i)
		slp && !ext_rst ##0 pin_s2_r[1] |=> !slp)
		else $error("async interrupt missed in sleep");

	chk_asy_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
		slp && asy_tick |=> async_timer_clock_o)
		else $error("async timer stopped in sleep");

	chk_adc_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		slp && mode_r == csss_pkg::SLP_ADC && presc_tick
		|=> converter_clock_o && !core_clock_o && !peripheral_clock_o)
		else $error("converter clock not alone in noise sleep");

	chk_src_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r != csss_pkg::ST_HOLD |=> $stable(src_r))
		else $error("source changed out of reset");

	chk_bad_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == csss_pkg::ST_BAD |=> int_rst_o && !core_clock_o && !converter_clock_o)
		else $error("clock released on reserved code");

	cov_boot: cover property (@(posedge clk_i) disable iff (rst_i)
		state_r == csss_pkg::ST_TOUT ##1 state_r == csss_pkg::ST_START);
	cov_deep_wake: cover property (@(posedge clk_i) disable iff (rst_i)
		state_r == csss_pkg::ST_WAKE ##1 state_r == csss_pkg::ST_RUN);
	cov_idle_wake: cover property (@(posedge clk_i) disable iff (rst_i)
		slp && io_on_sleep ##1 run);
	cov_reserved: cover property (@(posedge clk_i) disable iff (rst_i)
		state_r == csss_pkg::ST_BAD);
endmodule

// *** sim/csss_osc_model.sv ***
// Purpose: oscillator pins and fuse store that face the clock sequencer
// Assumes: clk_i runs at 100 MHz
// Notes: every lane toggles each 2 clk_i cycles, so one oscillator cycle is 4 clk_i cycles
`timescale 1ns/10ps
module csss_osc_model (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic [3:0] sel_i,
	input wire logic [1:0] stsel_i,
	input wire logic div_i,
	output logic [7:0] osc_o,
	output logic [3:0] clock_source_select_o,
	output logic [1:0] startup_time_select_o,
	output logic divide_by_eight_fuse_o
);
	logic half_r = 1'b0;
	logic [7:0] osc_r = 8'h00;

	// All lanes swing together; a stopped lane rests low so no stale edge is seen
	always_ff @(posedge clk_i) begin
		half_r <= ~half_r;
		if (half_r) begin
			osc_r <= run_i ? ~osc_r : 8'h00;
		end
	end

	// One process owns the lanes; the start value sits in the declaration
	assign osc_o = osc_r;

	// Fuse store: a programmed bit reads zero
	assign clock_source_select_o = sel_i;
	assign startup_time_select_o = stsel_i;
	assign divide_by_eight_fuse_o = div_i;
endmodule

// *** sim/csss_tb_top.sv ***
// Purpose: self-checking bench of the clock sequencer
// Assumes: shortened counts 16, 32 and 64 oscillator cycles
// Notes: one oscillator cycle lasts 4 clk_i cycles, so count bounds carry slack for phase
`timescale 1ns/10ps
`include "csss_map.svh"
module csss_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic rst_src = 1'b1;
	logic async_int = 1'b0;
	logic addr_match = 1'b0;
	logic periph_int = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic div = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [3:0] sel = 4'h2;
	logic [1:0] stsel = 2'h2;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, osc, d;
	logic [3:0] fsel;
	logic [1:0] fsut;
	logic fdiv, int_rst;
	logic [4:0] tk;
	logic [3:0] cs[8] = '{4'hF, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h0};
	logic [2:0] cp[8] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h5};
	int ce[8] = '{32, 1024, 32, 1024, 64, 64, 6, 6};
	int mismatches = 0;
	int n_checks = 0;
	int cyc = 0;
	int len, hi;
	int n[5];

	always #5 clk_i = ~clk_i;

	csss_osc_model peer (.clk_i(clk_i), .run_i(1'b1), .sel_i(sel), .stsel_i(stsel), .div_i(div),
		.osc_o(osc), .clock_source_select_o(fsel), .startup_time_select_o(fsut),
		.divide_by_eight_fuse_o(fdiv));

	csss_top #(.TOUT_8K_CYC(16'h0010), .START_16K_CYC(16'h0020), .START_32K_CYC(16'h0040)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .rst_src_i(rst_src), .osc_i(osc),
		.clock_source_select_i(fsel), .startup_time_select_i(fsut),
		.divide_by_eight_fuse_i(fdiv), .async_int_i(async_int), .addr_match_i(addr_match),
		.periph_int_i(periph_int), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .int_rst_o(int_rst), .core_clock_o(tk[0]),
		.peripheral_clock_o(tk[1]), .nvm_clock_o(tk[2]), .converter_clock_o(tk[3]),
		.async_timer_clock_o(tk[4]));

	// Single compare point, so every mismatch is reported the same way
	task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	function automatic logic [15:0] rng(input int v, input int lo, input int hi_v);
		return {15'h0000, v >= lo && v <= hi_v};
	endfunction

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic count(input int c);
		n = '{0, 0, 0, 0, 0};
		repeat (c) begin
			@(posedge clk_i);
			#1;
			foreach (n[i]) n[i] += (tk[i] === 1'b1);
		end
	endtask

	// Fuses change only under reset; len counts cycles from release of other resets
	task automatic boot(input logic [3:0] s, input logic [1:0] u, input logic v, input int lim);
		@(posedge clk_i);
		rst_i <= 1'b1;
		rst_src <= 1'b1;
		sel <= s;
		stsel <= u;
		div <= v;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_src <= 1'b0;
		len = 0;
		while (int_rst !== 1'b0 && len < lim) begin
			@(posedge clk_i);
			#1;
			len++;
		end
	endtask

	// Hang guard: well above the roughly 30000 cycles the tests need
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		boot(4'h2, 2'h2, 1'b0, 400);
		check("boot_len", rng(len, 84, 104), 16'h1);
		rd_reg(`CSSS_ADDR_FUSE);
		check("fuse", d, 8'h22);
		rd_reg(`CSSS_ADDR_STATUS);
		check("status", d, 8'h63);
		count(320);
		check("div8", rng(n[0], 9, 11), 16'h1);
		rd_reg(4'hC);
		check("unmapped", d, 8'h00);
		wr_reg(`CSSS_ADDR_CTRL, 8'h10);
		rd_reg(`CSSS_ADDR_CTRL);
		check("ctrl", d, 8'h10);
		count(80);
		check("nvm_off", n[2], 0);
		check("core_on", n[0] > 0, 1);
		wr_reg(`CSSS_ADDR_CTRL, 8'h00);
		$display("test boot done");
		// Each sleep mode: which domains run, who may wake it, whether start-up recurs
		for (int m = 0; m < 5; m++) begin
			wr_reg(`CSSS_ADDR_CTRL, 8'h08 | m[7:0]);
			periph_int <= (m != 0);
			count(80);
			check("core_sleep", n[0], 0);
			check("per_sleep", n[1] > 0, m == 0);
			check("conv_sleep", n[3] > 0, m <= 1);
			check("asy_sleep", n[4] > 0, 1);
			check("rst_sleep", int_rst, 1'b0);
			// Wake pins change on the edge, once each, never mid-cycle
			@(posedge clk_i);
			periph_int <= (m == 0);
			addr_match <= (m == 1);
			async_int <= (m >= 2);
			len = 0;
			hi = 0;
			while (tk[0] !== 1'b1 && len < 400) begin
				@(posedge clk_i);
				#1;
				len++;
				hi += (int_rst === 1'b1);
			end
			@(posedge clk_i);
			periph_int <= 1'b0;
			addr_match <= 1'b0;
			async_int <= 1'b0;
			check("wake_time", len < 400, 1);
			check("wake_rst", hi > 0, m == 2 || m == 3);
			if (m == 2)
				check("wake_len", rng(hi, 16, 44), 16'h1);
		end
		rst_src <= 1'b1;
		repeat (5) @(posedge clk_i);
		#1;
		check("rst_src", int_rst, 1'b1);
		$display("test sleep done");
		for (int i = 0; i < 8; i++) begin
			boot(cs[i], 2'h0, 1'b1, 4500);
			check("start_len", rng(len, 4 * (ce[i] - 1), 4 * ce[i] + 16), 16'h1);
			rd_reg(`CSSS_ADDR_STATUS);
			check("src", d[5:3], cp[i]);
		end
		count(80);
		check("nodiv", rng(n[0], 19, 21), 16'h1);
		$display("test sources done");
		boot(4'h0, 2'h1, 1'b1, 17000);
		check("tout_4k", rng(len, 4 * 4101, 4 * 4102 + 16), 16'h1);
		$display("test timeout done");
		boot(4'h1, 2'h2, 1'b1, 200);
		check("rsvd_rst", len, 200);
		rd_reg(`CSSS_ADDR_STATUS);
		check("rsvd_st", {d[7], d[2:0]}, 4'hE);
		count(80);
		check("rsvd_clk", n[0] + n[1] + n[2] + n[3], 0);
		$display("test reserved done");
		complete_run();
	end
endmodule
